// File: src/sync_hold.sv
// Purpose: Flywheel, restart, correction modes and data-available pacing.
// Assumes: Block strobes come from the syndrome stage with error class.
// Notes:   The FIFO paces words to the controller's read port.
module sync_hold
    import sync_hold_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      rstn,
    input  wire logic                      power_reset_n,
    input  wire sync_hold_pkg::block_type  block_in,
    input  wire logic                      block_strobe,
    input  wire logic                      pair_seen,
    input  wire logic                      bit_slip_detected,
    input  wire logic [1:0]                slip_match,
    input  wire logic                      restart_search_ctrl,
    input  wire logic                      corr_mode_bit0,
    input  wire logic                      corr_mode_bit1,
    input  wire logic                      avail_mode_bit0,
    input  wire logic                      avail_mode_bit1,
    input  wire logic [5:0]                good_block_threshold,
    input  wire logic [5:0]                loss_bad_block_threshold,
    input  wire logic                      status_read,
    input  wire logic                      word_ready,
    output logic                           synced,
    output logic                           data_avail_n,
    output logic                           overflow_flag,
    output logic                           output_select,
    output logic                           restart_clear_pulse,
    output logic                           search_restart,
    output logic [1:0]                     slip_shift,
    output logic [5:0]                     good_count,
    output logic [5:0]                     bad_count,
    output logic [1:0]                     block_class,
    output sync_hold_pkg::out_word_type    word_out,
    output logic                           word_valid
);
    import sync_hold_pkg::*;

    // ------------------------------------------------------------
    // Block classification
    // ------------------------------------------------------------
    logic [1:0] corr_mode, avail_mode;
    logic       blk_good, blk_search_ok;

    assign corr_mode  = {corr_mode_bit1, corr_mode_bit0};
    assign avail_mode = {avail_mode_bit1, avail_mode_bit0};

    // Decides whether a block counts as valid under a correction mode.
    function automatic logic is_valid(input logic [1:0] mode,
                                      input logic [1:0] err,
                                      input logic       locked);
        logic ok;
        ok = 1'b0;
        unique case (mode)
            CORR_NONE:   ok = (err == ERR_CLEAN);
            CORR_TWO:    ok = (err == ERR_CLEAN) || (err == ERR_FIX2);
            CORR_FIVE:   ok = (err != ERR_BAD);
            CORR_STRICT: ok = locked ? (err != ERR_BAD)
                                     : (err == ERR_CLEAN);
        endcase
        return ok;
    endfunction : is_valid

    assign blk_good      = is_valid(corr_mode, block_in.err, 1'b1);
    assign blk_search_ok = is_valid(corr_mode, block_in.err, 1'b0);

    // ------------------------------------------------------------
    // Lock state and flywheel counters
    // ------------------------------------------------------------
    sync_state_type state_q, state_d;
    logic [5:0] good_q, good_d, bad_q, bad_d;
    logic       loss_d, clr_pulse_d, clr_pulse_q;
    logic [1:0] slip_q, slip_d;

    always_comb begin
        state_d     = state_q;
        good_d      = good_q;
        bad_d       = bad_q;
        loss_d      = 1'b0;
        clr_pulse_d = 1'b0;
        slip_d      = 2'h0;
        unique case (state_q)
            ST_SEARCH: begin
                if (restart_search_ctrl) begin
                    state_d = ST_RESTART;
                end else if (block_strobe && pair_seen
                             && blk_search_ok) begin
                    state_d = ST_SYNC;
                end
            end
            ST_SYNC: begin
                if (restart_search_ctrl) begin
                    state_d = ST_RESTART;
                    good_d  = CNT_RESET;
                    bad_d   = CNT_RESET;
                end else begin
                    if (bit_slip_detected) begin
                        slip_d = slip_match;
                    end
                    if (block_strobe) begin
                        if (blk_good) begin
                            good_d = good_q + 6'h01;
                        end else begin
                            bad_d = bad_q + 6'h01;
                        end
                    end
                    if (bad_d == loss_bad_block_threshold
                        && block_strobe && !blk_good) begin
                        state_d = ST_SEARCH;
                        good_d  = CNT_RESET;
                        bad_d   = CNT_RESET;
                        loss_d  = 1'b1;
                    end else if (good_d == good_block_threshold
                                 && block_strobe && blk_good) begin
                        good_d = CNT_RESET;
                        bad_d  = CNT_RESET;
                    end
                end
            end
            ST_RESTART: begin
                // One cycle here lets the search logic see the restart.
                state_d     = ST_SEARCH;
                good_d      = CNT_RESET;
                bad_d       = CNT_RESET;
                clr_pulse_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q     <= ST_SEARCH;
            good_q      <= CNT_RESET;
            bad_q       <= CNT_RESET;
            clr_pulse_q <= 1'b0;
            slip_q      <= 2'h0;
        end else begin
            state_q     <= state_d;
            good_q      <= good_d;
            bad_q       <= bad_d;
            clr_pulse_q <= clr_pulse_d;
            slip_q      <= slip_d;
        end
    end

    // ------------------------------------------------------------
    // Data-available pacing, overflow and power reset
    // ------------------------------------------------------------
    logic        locked, present, pair_q, pair_d;
    logic        dav_q, dav_d, ovf_q, ovf_d, pwr_q, pwr_d;
    logic [31:0] hold_q, hold_d;
    logic        fifo_ready, fifo_push;
    out_word_type word_d;

    assign locked = (state_q == ST_SYNC);

    always_comb begin
        present = 1'b0;
        pair_d  = pair_q;
        pwr_d   = pwr_q;
        if (avail_mode != AVAIL_BYPASS) begin
            if (locked && block_strobe) begin
                if (avail_mode == AVAIL_REDUCED) begin
                    pair_d  = !pair_q;
                    present = pair_q;
                end else begin
                    present = 1'b1;
                end
            end else if (!locked && block_strobe) begin
                if (avail_mode == AVAIL_FAST_PI && blk_search_ok
                    && (block_in.id == ID_A
                        || block_in.id == ID_C_PRIME)) begin
                    present = 1'b1;
                end
                if (pair_seen && blk_search_ok) begin
                    present = 1'b1;
                end
            end
            if (loss_d || pwr_q) begin
                present = 1'b1;
                pwr_d   = 1'b0;
            end
        end
        if (!locked) begin
            pair_d = 1'b0;
        end
        // A fresh reset beats the report taken in this cycle.
        if (!power_reset_n) begin
            pwr_d = 1'b1;
        end
    end

    always_comb begin
        dav_d     = dav_q;
        hold_d    = hold_q;
        ovf_d     = ovf_q;
        fifo_push = 1'b0;
        if (dav_q) begin
            if (hold_q == 32'h0 || status_read) begin
                dav_d = 1'b0;
            end else begin
                hold_d = hold_q - 32'h1;
            end
        end
        if (locked && block_strobe && !fifo_ready) begin
            ovf_d = 1'b1;
        end
        if (present && !dav_q && !ovf_q && fifo_ready) begin
            fifo_push = 1'b1;
            dav_d     = 1'b1;
            hold_d    = DAV_HOLD_CYC - 1;
        end
        if (status_read && !(locked && block_strobe
                             && !fifo_ready)) begin
            ovf_d = 1'b0;
        end
        if (state_q == ST_RESTART) begin
            ovf_d = 1'b0;
        end
        word_d.info   = block_in.info;
        word_d.id     = block_in.id;
        word_d.err    = block_in.err;
        word_d.synced = locked;
        word_d.spare  = 10'h000;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dav_q  <= 1'b0;
            hold_q <= 32'h0;
            ovf_q  <= 1'b0;
            pair_q <= 1'b0;
            pwr_q  <= 1'b1;
        end else begin
            dav_q  <= dav_d;
            hold_q <= hold_d;
            ovf_q  <= ovf_d;
            pair_q <= pair_d;
            pwr_q  <= pwr_d;
        end
    end

    // ------------------------------------------------------------
    // Word buffer toward the controller
    // ------------------------------------------------------------
    // Words stay queued until read or flushed by a restart, so they remain
    // readable beyond the release of data-available.
    out_word_type fifo_out;
    logic         fifo_valid;
    out_word_type word_out_d;
    logic         word_valid_d, fifo_take;

    word_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clock     (clock),
        .rstn      (rstn),
        .flush     (state_q == ST_RESTART),
        .in_data   (word_d),
        .in_valid  (fifo_push),
        .in_ready  (fifo_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (fifo_take)
    );

    // The head moves on only when the output register is free or taken.
    always_comb begin
        fifo_take    = fifo_valid && (!word_valid || word_ready);
        word_out_d   = word_out;
        word_valid_d = word_valid && !word_ready;
        if (fifo_take) begin
            word_out_d   = fifo_out;
            word_valid_d = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            synced              <= 1'b0;
            data_avail_n        <= 1'b1;
            overflow_flag       <= 1'b0;
            output_select       <= 1'b1;
            restart_clear_pulse <= 1'b0;
            search_restart      <= 1'b0;
            slip_shift          <= 2'h0;
            good_count          <= CNT_RESET;
            bad_count           <= CNT_RESET;
            block_class         <= 2'h0;
            word_out            <= '0;
            word_valid          <= 1'b0;
        end else begin
            synced              <= (state_d == ST_SYNC);
            data_avail_n        <= !dav_d;
            overflow_flag       <= ovf_d;
            output_select       <= (avail_mode != AVAIL_BYPASS);
            restart_clear_pulse <= clr_pulse_d;
            search_restart      <= clr_pulse_d || loss_d;
            slip_shift          <= slip_d;
            good_count          <= good_d;
            bad_count           <= bad_d;
            block_class         <= {blk_good, blk_search_ok};
            word_out            <= word_out_d;
            word_valid          <= word_valid_d;
        end
    end

endmodule : sync_hold

// File: include/sync_hold_pkg.sv
// Purpose: Shared constants and carrier types for the sync-hold block.
// Assumes: 250 MHz system clock; blocks arrive as decoded strobes.
// Notes:   Times are kept in their own units with derived cycle counts.
package sync_hold_pkg;

    localparam int unsigned CLOCK_HZ      = 250_000_000;
    localparam int unsigned DAV_HOLD_US   = 10_000;
    localparam int unsigned DAV_HOLD_CYC  = CLOCK_HZ / 1_000_000 * DAV_HOLD_US;
    localparam int unsigned CNT_W         = 6;
    localparam int unsigned FIFO_W        = 32;
    localparam int unsigned FIFO_D        = 4;
    localparam logic [5:0]  CNT_RESET     = 6'h00;
    localparam logic [1:0]  CORR_NONE     = 2'h0;
    localparam logic [1:0]  CORR_TWO      = 2'h1;
    localparam logic [1:0]  CORR_FIVE     = 2'h2;
    localparam logic [1:0]  CORR_STRICT   = 2'h3;
    localparam logic [1:0]  AVAIL_STD     = 2'h0;
    localparam logic [1:0]  AVAIL_FAST_PI = 2'h1;
    localparam logic [1:0]  AVAIL_REDUCED = 2'h2;
    localparam logic [1:0]  AVAIL_BYPASS  = 2'h3;
    localparam logic [1:0]  ERR_CLEAN     = 2'h0;
    localparam logic [1:0]  ERR_FIX2      = 2'h1;
    localparam logic [1:0]  ERR_FIX5      = 2'h2;
    localparam logic [1:0]  ERR_BAD       = 2'h3;
    localparam logic [2:0]  ID_A          = 3'h0;
    localparam logic [2:0]  ID_C_PRIME    = 3'h4;

    // One decoded block from the syndrome stage.
    typedef struct packed {
        logic [15:0] info;
        logic [2:0]  id;
        logic [1:0]  err;
    } block_type;

    // Word held for the controller: one info plus its id, error class and status.
    typedef struct packed {
        logic [15:0] info;
        logic [2:0]  id;
        logic [1:0]  err;
        logic        synced;
        logic [9:0]  spare;
    } out_word_type;

    typedef enum logic [2:0] {
        ST_SEARCH = 3'b001,
        ST_SYNC   = 3'b010,
        ST_RESTART = 3'b100
    } sync_state_type;

endpackage : sync_hold_pkg

// File: src/word_fifo.sv
// Purpose: Small valid/ready FIFO holding words for the controller.
// Assumes: Single clock; width and depth are parameters.
// Notes:   Full and empty are exact; only a full count stalls the filling side.
module word_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    always_comb begin
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_d = wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
        if (flush) begin
            wr_d  = '0;
            rd_d  = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

endmodule : word_fifo

// File: test/sync_hold_asserts.sv
// Purpose: Port-level checks of the sync-hold block.
// Assumes: One clock; counts are compared after the increment.
// Notes:   A threshold of zero matches only when a count wraps from 63, so it is left out.
module sync_hold_asserts
    import sync_hold_pkg::*;
(
    input wire logic                     clock,
    input wire logic                     rstn,
    input wire logic                     power_reset_n,
    input wire sync_hold_pkg::block_type block_in,
    input wire logic                     block_strobe,
    input wire logic                     restart_search_ctrl,
    input wire logic                     corr_mode_bit0,
    input wire logic                     corr_mode_bit1,
    input wire logic                     avail_mode_bit0,
    input wire logic                     avail_mode_bit1,
    input wire logic [5:0]               good_block_threshold,
    input wire logic [5:0]               loss_bad_block_threshold,
    input wire logic                     status_read,
    input wire logic                     synced,
    input wire logic                     data_avail_n,
    input wire logic                     overflow_flag,
    input wire logic                     output_select,
    input wire logic                     restart_clear_pulse,
    input wire logic [5:0]               good_count,
    input wire logic [5:0]               bad_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    logic [1:0]  corr;
    logic [1:0]  avail;
    logic        good_blk;
    logic [21:0] low_d;
    logic [21:0] low_q;

    assign corr = {corr_mode_bit1, corr_mode_bit0};
    assign avail = {avail_mode_bit1, avail_mode_bit0};
    // Five-bit modes both take every correctable class while locked.
    assign good_blk = block_in.err == ERR_CLEAN
        || (corr == CORR_TWO && block_in.err == ERR_FIX2)
        || (corr[1] && block_in.err != ERR_BAD);

    always_comb low_d = data_avail_n ? 22'h000000 : low_q + 22'h000001;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) low_q <= 22'h000000;
        else low_q <= low_d;
    end

    sequence s_lock_blk;
        synced && block_strobe && !restart_search_ctrl;
    endsequence
    sequence s_cleared;
        good_count == CNT_RESET && bad_count == CNT_RESET;
    endsequence

    AST_GOOD_INC: assert property (
        s_lock_blk ##0 (good_blk
            && good_count + 6'h01 != good_block_threshold)
        |=> good_count == $past(good_count) + 6'h01 && $stable(bad_count))
        else $error("good count did not step");
    AST_BAD_INC: assert property (
        s_lock_blk ##0 (!good_blk
            && bad_count + 6'h01 != loss_bad_block_threshold)
        |=> bad_count == $past(bad_count) + 6'h01 && $stable(good_count))
        else $error("bad count did not step");
    AST_GOOD_WRAP: assert property (
        s_lock_blk ##0 (good_blk && good_block_threshold != 6'h00
            && good_count + 6'h01 == good_block_threshold)
        |=> s_cleared ##0 synced)
        else $error("good threshold did not clear counts");
    AST_LOSS: assert property (
        s_lock_blk ##0 (!good_blk && loss_bad_block_threshold != 6'h00
            && bad_count + 6'h01 == loss_bad_block_threshold)
        |=> !synced ##0 s_cleared)
        else $error("loss threshold did not drop lock");
    AST_IDLE_COUNTS: assert property (
        !synced && $past(!synced) |-> s_cleared)
        else $error("counts moved while searching");
    AST_RESTART: assert property (
        $rose(restart_search_ctrl)
        |=> ##[0:2] restart_clear_pulse ##0 !synced)
        else $error("restart did not complete");
    AST_BYPASS: assert property (
        $past(avail) == AVAIL_BYPASS |-> !output_select)
        else $error("output select high in bypass");
    AST_NO_BYPASS: assert property (
        $past(avail) != AVAIL_BYPASS |-> output_select)
        else $error("output select low outside bypass");
    AST_DAV_PRESENT: assert property (
        s_lock_blk ##0 (data_avail_n && !overflow_flag && !avail[1])
        |=> !data_avail_n || overflow_flag)
        else $error("locked block not presented");
    AST_DAV_RELEASE: assert property (
        !data_avail_n && status_read && power_reset_n |=> data_avail_n)
        else $error("status read did not release data available");
    AST_DAV_TIMEOUT: assert property (
        low_q <= DAV_HOLD_CYC)
        else $error("data available held too long");
    AST_OVF_SET: assert property (
        $rose(overflow_flag) |-> $past(synced && block_strobe))
        else $error("overflow without a locked block");
    AST_OVF_CLEAR: assert property (
        $fell(overflow_flag) |-> $past(status_read || restart_search_ctrl))
        else $error("overflow cleared without read or restart");
endmodule : sync_hold_asserts

bind sync_hold sync_hold_asserts i_chk (.*);

// File: test/ctrl_model.sv
// Purpose: Main controller model: reads status and pops held words.
// Assumes: Reads start a set number of cycles after data-available.
// Notes:   Stall holds the word port off so the buffer can fill.
module ctrl_model (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       data_avail_n,
    input  wire logic       word_valid,
    input  wire logic       stall,
    input  wire logic       read_now,
    input  wire logic [7:0] delay,
    output logic            status_read,
    output logic            word_ready,
    output int              pops
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_q;

    // The guard on status_read keeps one read per low phase.
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_read <= 1'b0;
            word_ready <= 1'b0;
            wait_q <= 8'h00;
            pops <= 0;
        end else begin
            word_ready <= !stall;
            if (word_ready && word_valid) pops <= pops + 1;
            status_read <= 1'b0;
            if (read_now || (!data_avail_n && wait_q >= delay
                             && !status_read)) begin
                status_read <= 1'b1;
                wait_q <= 8'h00;
            end else if (!data_avail_n) wait_q <= wait_q + 8'h01;
            else wait_q <= 8'h00;
        end
    end
endmodule : ctrl_model

// File: test/sync_hold_tb.sv
// Purpose: Self-checking bench for the sync-hold block.
// Assumes: The controller model answers every data-available.
// Notes:   The long hold of data-available is left to the checker.
module sync_hold_tb
    import sync_hold_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock = 1'b0;
    logic        rstn = 1'b1;
    logic        power_reset_n = 1'b1;
    block_type   block_in = '0;
    logic        block_strobe = 1'b0;
    logic        pair_seen = 1'b0;
    logic        bit_slip_detected = 1'b0;
    logic [1:0]  slip_match = 2'h0;
    logic        restart_search_ctrl = 1'b0;
    logic        corr_mode_bit0 = 1'b0;
    logic        corr_mode_bit1 = 1'b0;
    logic        avail_mode_bit0 = 1'b0;
    logic        avail_mode_bit1 = 1'b0;
    logic [5:0]  good_block_threshold = 6'h3F;
    logic [5:0]  loss_bad_block_threshold = 6'h3F;
    logic        status_read, word_ready, synced, data_avail_n;
    logic        overflow_flag, output_select, restart_clear_pulse;
    logic        search_restart, word_valid;
    logic [1:0]  slip_shift, block_class;
    logic [5:0]  good_count, bad_count;
    out_word_type word_out;
    logic        stall = 1'b0;
    logic        read_now = 1'b0;
    logic [7:0]  delay = 8'h02;
    logic        dav_q = 1'b1;
    int          pops, falls, p0, n_errors, comparisons, exp_good, exp_bad;
    int          restarts;
    logic        g;

    sync_hold i_dut (.*);
    ctrl_model i_ctrl (.clock(clock), .rstn(rstn), .data_avail_n(data_avail_n),
        .word_valid(word_valid), .stall(stall), .read_now(read_now),
        .delay(delay), .status_read(status_read), .word_ready(word_ready),
        .pops(pops));

    initial forever #2 clock = ~clock;
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        print_verdict();
    end
    always @(negedge clock) begin
        if (dav_q === 1'b1 && data_avail_n === 1'b0) falls++;
        dav_q = data_avail_n;
        if (search_restart === 1'b1) restarts++;
    end

    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic send(input logic [2:0] id, input logic [1:0] err,
                        input logic pair);
        @(negedge clock);
        block_in = '{16'hA5C3, id, err};
        block_strobe = 1'b1;
        pair_seen = pair;
        @(negedge clock);
        block_strobe = 1'b0;
        pair_seen = 1'b0;
        repeat (30) @(negedge clock);
    endtask : send
    task automatic modes(input logic [1:0] c, input logic [1:0] a);
        @(negedge clock);
        {corr_mode_bit1, corr_mode_bit0} = c;
        {avail_mode_bit1, avail_mode_bit0} = a;
    endtask : modes
    task automatic restart();
        int i;
        @(negedge clock);
        restart_search_ctrl = 1'b1;
        for (i = 0; i < 20 && restart_clear_pulse !== 1'b1; i++)
            @(negedge clock);
        restart_search_ctrl = 1'b0;
        check(restart_clear_pulse, 1'b1);
        repeat (3) @(negedge clock);
        check(synced, 1'b0);
        check({good_count, bad_count}, 12'h000);
    endtask : restart

    initial begin
        rstn = 1'b0;
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        repeat (10) @(negedge clock);
        check(falls, 1);
        check({synced, overflow_flag, output_select}, 3'b001);
        p0 = falls;
        send(ID_A, ERR_CLEAN, 1'b0);
        check(falls - p0, 0);
        modes(CORR_NONE, AVAIL_FAST_PI);
        send(ID_A, ERR_CLEAN, 1'b0);
        send(3'h1, ERR_CLEAN, 1'b0);
        send(ID_C_PRIME, ERR_CLEAN, 1'b0);
        check(falls - p0, 2);
        modes(CORR_NONE, AVAIL_STD);
        send(ID_A, ERR_CLEAN, 1'b1);
        check(synced, 1'b1);
        check(falls - p0, 3);
        p0 = falls;
        for (int m = 0; m < 4; m++) begin
            modes(2'(m), AVAIL_STD);
            for (int e = 0; e < 4; e++) begin
                g = e == 0 || (m == 1 && e == 1) || (m > 1 && e != 3);
                if (g) exp_good++;
                else exp_bad++;
                send(ID_A, 2'(e), 1'b0);
                check(good_count, 6'(exp_good));
                check(bad_count, 6'(exp_bad));
                check(block_class, {g, g && !(m == 3 && e != 0)});
            end
        end
        check(falls - p0, 16);
        bit_slip_detected = 1'b1;
        slip_match = 2'h2;
        @(negedge clock);
        bit_slip_detected = 1'b0;
        check(slip_shift, 2'h2);
        @(negedge clock);
        check(slip_shift, 2'h0);
        restart();
        good_block_threshold = 6'h03;
        loss_bad_block_threshold = 6'h02;
        send(ID_A, ERR_CLEAN, 1'b1);
        send(ID_A, ERR_CLEAN, 1'b0);
        send(ID_A, ERR_CLEAN, 1'b0);
        check(good_count, 6'h02);
        send(ID_A, ERR_CLEAN, 1'b0);
        check({synced, good_count, bad_count}, 13'h1000);
        p0 = falls;
        send(ID_A, ERR_BAD, 1'b0);
        send(ID_A, ERR_BAD, 1'b0);
        check({synced, good_count, bad_count}, 13'h0000);
        check(falls - p0 >= 2, 1'b1);
        check(restarts, 2);
        loss_bad_block_threshold = 6'h3F;
        modes(CORR_NONE, AVAIL_REDUCED);
        send(ID_A, ERR_CLEAN, 1'b1);
        p0 = falls;
        repeat (4) send(ID_A, ERR_CLEAN, 1'b0);
        check(falls - p0, 2);
        modes(CORR_NONE, AVAIL_BYPASS);
        repeat (2) @(negedge clock);
        check(output_select, 1'b0);
        modes(CORR_NONE, AVAIL_STD);
        repeat (2) @(negedge clock);
        check(output_select, 1'b1);
        stall = 1'b1;
        p0 = pops;
        repeat (6) send(ID_A, ERR_CLEAN, 1'b0);
        check({word_valid, overflow_flag}, 2'b11);
        check(word_out, {16'hA5C3, ID_A, ERR_CLEAN, 1'b1, 10'h000});
        send(ID_A, ERR_CLEAN, 1'b0);
        stall = 1'b0;
        repeat (20) @(negedge clock);
        // One word waits in the output register beyond the buffer.
        check(pops - p0, FIFO_D + 1);
        check({word_valid, overflow_flag}, 2'b01);
        read_now = 1'b1;
        @(negedge clock);
        read_now = 1'b0;
        repeat (3) @(negedge clock);
        check(overflow_flag, 1'b0);
        p0 = falls;
        power_reset_n = 1'b0;
        @(negedge clock);
        power_reset_n = 1'b1;
        repeat (10) @(negedge clock);
        check(falls - p0, 1);
        print_verdict();
    end
endmodule : sync_hold_tb
